// ### hw/rcr_pkg.sv
// Purpose: Constants and types for the regulator control register bank
// Assumes: Control registers are 16 bits wide, interrupt registers 2 bits, one per aligned 32-bit AXI4-Lite word
// Notes: Byte address of a register is four times its index
package rcr_pkg;
   localparam int RCR_ADDR_W = 18;
   localparam int RCR_IDX_W = 16;
   localparam int RCR_IRQ_W = 2;
   // Register indices; byte address = index * 4
   localparam logic [15:0] IDX_B_SLEEP = 16'h407F;
   localparam logic [15:0] IDX_C_GEN = 16'h4080;
   localparam logic [15:0] IDX_C_ON = 16'h4081;
   localparam logic [15:0] IDX_C_SLEEP = 16'h4082;
   localparam logic [15:0] IDX_IRQ_STAT = 16'h4090;
   localparam logic [15:0] IDX_IRQ_MASK = 16'h4091;
   // Field positions
   localparam int UV_ACT_LSB = 14;
   localparam int HWC_SRC_LSB = 11;
   localparam int HWC_VPICK_BIT = 10;
   localparam int HWC_STATE_LSB = 8;
   localparam int FLOAT_BIT = 7;
   localparam int SWITCH_BIT = 6;
   localparam int SLOT_LSB = 13;
   localparam int MODE_BIT = 8;
   localparam int VCODE_LSB = 0;
   localparam int IRQ_UV_BIT = 0;
   localparam int IRQ_SHUT_BIT = 1;
   // Reset values and writable bits
   localparam logic [15:0] GEN_RST = 16'h0200;
   localparam logic [15:0] ON_RST = 16'h0000;
   localparam logic [15:0] SLEEP_RST = 16'h0100;
   localparam logic [15:0] B_SLEEP_RST = 16'h0000;
   localparam logic [15:0] GEN_MASK = 16'hDFC0;
   localparam logic [15:0] SLOTREG_MASK = 16'hE11F;
   localparam logic [15:0] B_SLEEP_MASK = 16'h001F;
   // Field codes
   localparam logic [1:0] UV_IGNORE = 2'h0;
   localparam logic [1:0] UV_REG_OFF = 2'h1;
   localparam logic [1:0] UV_SYS_OFF = 2'h2;
   localparam logic [1:0] HWC_NONE = 2'h0;
   localparam logic [1:0] HWC_IN1 = 2'h1;
   localparam logic [1:0] HWC_IN2 = 2'h2;
   localparam logic [1:0] HWC_EITHER = 2'h3;
   localparam logic [1:0] HWS_OFF = 2'h1;
   localparam logic [1:0] HWS_FOLLOW = 2'h3;
   localparam logic [2:0] SLOT_NEVER = 3'h0;
   localparam logic [2:0] SLOT_LAST = 3'h5;
   localparam logic [2:0] SLOT_HWEN1 = 3'h6;
   localparam logic [2:0] SLOT_HWEN2 = 3'h7;
   localparam logic [2:0] SLP_TRANS_TS5 = 3'h0;
   localparam logic [2:0] SLP_DIS_FIRST = 3'h1;
   localparam logic [2:0] SLP_DIS_LAST = 3'h5;
   localparam logic [2:0] SLP_TRANS_TS3 = 3'h6;
   localparam logic [2:0] SLP_DIS_BASE = 3'h6;
   localparam logic [2:0] TS1 = 3'h1;
   localparam logic [2:0] TS3 = 3'h3;
   localparam logic [2:0] TS5 = 3'h5;
   // Voltage code mapping in millivolts
   localparam logic [11:0] V_BASE_MV = 12'd1000;
   localparam logic [11:0] V_FINE_MV = 12'd50;
   localparam logic [4:0] V_KNEE_CODE = 5'h0D;
   localparam logic [11:0] V_KNEE_MV = 12'd1700;
   localparam logic [11:0] V_COARSE_MV = 12'd100;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ST_OFF, ST_ON, ST_SLEEP} rcr_state_t;
endpackage

// ### hw/rcr_regulator_control.sv
// Purpose: Control registers and state logic for one low-dropout regulator
// Assumes: Sequencer, hardware control and enable inputs are synchronous to clk
// Notes: AXI4-Lite slave, answers a read one cycle and a write two cycles after a complete request
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module rcr_regulator_control
   import rcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [RCR_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [RCR_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic hwControl1,
   input wire logic hwControl2,
   input wire logic hwEnable1,
   input wire logic hwEnable2,
   input wire logic seqStep,
   input wire logic seqSleeping,
   input wire logic [2:0] seqSlot,
   input wire logic underVoltage,
   output logic regEnable,
   output logic [4:0] voltageCode,
   output logic [11:0] outputMillivolt,
   output logic lowPower,
   output logic outputDischarge,
   output logic switchMode,
   output logic priorSleepCode,
   output logic systemShutdown,
   output logic irq
);
   logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
   logic [RCR_IDX_W-1:0] awIdx_ff;
   logic [31:0] wData_ff, rdata_ff;
   logic [3:0] wStrb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [15:0] bSleep_ff, gen_ff, on_ff, sleep_ff;
   logic [RCR_IRQ_W-1:0] irqStat_ff, irqMask_ff, irqSet;
   logic uvPrev_ff, uvRise, hwEnPrev_ff;
   rcr_state_t state_ff, nxt_state;
   logic regEnable_ff, lowPower_ff, discharge_ff, switch_ff, shutdown_ff;
   logic [4:0] vcode_ff, nxt_vcode;
   logic [11:0] mv_ff, nxt_mv;
   logic nxt_enable, nxt_lowPower;
   logic doWrite, arTake, hwActive, hwEnAssigned, hwEnSel, mapped;
   logic [RCR_IDX_W-1:0] arIdx;
   logic [1:0] uvAct, hwSrc, hwState;
   logic [2:0] onSlot, slpSlot, slpTarget;

   // Byte-lane merge limited to the implemented bits
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s, input logic [15:0] m);
      logic [15:0] v;
      v = old;
      if (s[0]) begin
         v[7:0] = d[7:0];
      end
      if (s[1]) begin
         v[15:8] = d[15:8];
      end
      return v & m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   assign awready = !awHeld_ff && !bvalid_ff;
   assign wready = !wHeld_ff && !bvalid_ff;
   assign arready = !rvalid_ff;
   assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
   assign arTake = arvalid && arready;
   assign arIdx = araddr[RCR_ADDR_W-1:2];
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_ff <= 1'b0;
         awIdx_ff <= 16'h0000;
      end else if (awvalid && awready) begin
         awHeld_ff <= 1'b1;
         awIdx_ff <= awaddr[RCR_ADDR_W-1:2];
      end else if (doWrite) begin
         awHeld_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wHeld_ff <= 1'b0;
         wData_ff <= 32'h00000000;
         wStrb_ff <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld_ff <= 1'b1;
         wData_ff <= wdata;
         wStrb_ff <= wstrb;
      end else if (doWrite) begin
         wHeld_ff <= 1'b0;
      end
   end

   always_comb begin
      case (awIdx_ff)
         IDX_B_SLEEP, IDX_C_GEN, IDX_C_ON, IDX_C_SLEEP, IDX_IRQ_STAT, IDX_IRQ_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Registers; status is read-only, writes to it are accepted and dropped
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bSleep_ff <= B_SLEEP_RST;
         gen_ff <= GEN_RST;
         on_ff <= ON_RST;
         sleep_ff <= SLEEP_RST;
         irqMask_ff <= '0;
      end else if (doWrite) begin
         if (awIdx_ff == IDX_B_SLEEP) begin
            bSleep_ff <= merge(bSleep_ff, wData_ff, wStrb_ff, B_SLEEP_MASK);
         end
         if (awIdx_ff == IDX_C_GEN) begin
            gen_ff <= merge(gen_ff, wData_ff, wStrb_ff, GEN_MASK);
         end
         if (awIdx_ff == IDX_C_ON) begin
            on_ff <= merge(on_ff, wData_ff, wStrb_ff, SLOTREG_MASK);
         end
         if (awIdx_ff == IDX_C_SLEEP) begin
            sleep_ff <= merge(sleep_ff, wData_ff, wStrb_ff, SLOTREG_MASK);
         end
         if (awIdx_ff == IDX_IRQ_MASK && wStrb_ff[0]) begin
            irqMask_ff <= wData_ff[RCR_IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= RESP_OKAY;
      end else if (arTake) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= RESP_OKAY;
         case (arIdx)
            IDX_B_SLEEP: rdata_ff <= {16'h0000, bSleep_ff};
            IDX_C_GEN: rdata_ff <= {16'h0000, gen_ff};
            IDX_C_ON: rdata_ff <= {16'h0000, on_ff};
            IDX_C_SLEEP: rdata_ff <= {16'h0000, sleep_ff};
            IDX_IRQ_STAT: rdata_ff <= {{(32-RCR_IRQ_W){1'b0}}, irqStat_ff};
            IDX_IRQ_MASK: rdata_ff <= {{(32-RCR_IRQ_W){1'b0}}, irqMask_ff};
            default: begin
               rdata_ff <= 32'h00000000;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field decode
   assign uvAct = gen_ff[UV_ACT_LSB +: 2];
   assign hwSrc = gen_ff[HWC_SRC_LSB +: 2];
   assign hwState = gen_ff[HWC_STATE_LSB +: 2];
   assign onSlot = on_ff[SLOT_LSB +: 3];
   assign slpSlot = sleep_ff[SLOT_LSB +: 3];
   assign priorSleepCode = |bSleep_ff[VCODE_LSB +: 5];

   always_comb begin
      case (hwSrc)
         HWC_IN1: hwActive = hwControl1;
         HWC_IN2: hwActive = hwControl2;
         HWC_EITHER: hwActive = hwControl1 || hwControl2;
         default: hwActive = 1'b0;
      endcase
   end

   assign hwEnAssigned = (onSlot == SLOT_HWEN1) || (onSlot == SLOT_HWEN2);
   assign hwEnSel = (onSlot == SLOT_HWEN1) ? hwEnable1 : hwEnable2;

   // Timeslot at which the sleep code acts
   always_comb begin
      case (slpSlot)
         SLP_TRANS_TS5: slpTarget = TS5;
         SLP_TRANS_TS3: slpTarget = TS3;
         SLOT_HWEN2: slpTarget = TS1;
         default: slpTarget = SLP_DIS_BASE - slpSlot;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Undervoltage events and interrupt
   assign uvRise = underVoltage && !uvPrev_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         uvPrev_ff <= 1'b0;
         hwEnPrev_ff <= 1'b0;
      end else begin
         uvPrev_ff <= underVoltage;
         hwEnPrev_ff <= hwEnSel;
      end
   end

   always_comb begin
      irqSet = '0;
      irqSet[IRQ_UV_BIT] = uvRise;
      irqSet[IRQ_SHUT_BIT] = uvRise && (uvAct == UV_REG_OFF);
   end

   // A set in the clearing read's cycle survives
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_ff <= '0;
      end else if (arTake && arIdx == IDX_IRQ_STAT) begin
         irqStat_ff <= irqSet;
      end else begin
         irqStat_ff <= irqStat_ff | irqSet;
      end
   end

   assign irq = |(irqStat_ff & irqMask_ff);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shutdown_ff <= 1'b0;
      end else begin
         shutdown_ff <= uvRise && (uvAct == UV_SYS_OFF);
      end
   end
   assign systemShutdown = shutdown_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Regulator state; undervoltage shutdown outranks any sequencer step
   always_comb begin
      nxt_state = state_ff;
      if (uvRise && uvAct == UV_REG_OFF) begin
         nxt_state = ST_OFF;
      end else if (hwEnAssigned) begin
         if (hwEnSel && !hwEnPrev_ff) begin
            nxt_state = ST_ON;
         end else if (!hwEnSel && hwEnPrev_ff) begin
            nxt_state = ST_OFF;
         end else if (seqStep && seqSleeping && seqSlot == slpTarget && state_ff == ST_ON) begin
            nxt_state = ST_SLEEP;
         end
      end else if (seqStep && !seqSleeping && onSlot != SLOT_NEVER && seqSlot == onSlot) begin
         nxt_state = ST_ON;
      end else if (seqStep && seqSleeping && seqSlot == slpTarget && state_ff == ST_ON) begin
         if (slpSlot >= SLP_DIS_FIRST && slpSlot <= SLP_DIS_LAST) begin
            nxt_state = ST_OFF;
         end else begin
            nxt_state = ST_SLEEP;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output settings; active hardware control overrides the voltage code, and either forces the enable off or overrides low power
   always_comb begin
      nxt_enable = (state_ff != ST_OFF);
      nxt_vcode = (state_ff == ST_SLEEP) ? sleep_ff[VCODE_LSB +: 5] : on_ff[VCODE_LSB +: 5];
      nxt_lowPower = (state_ff == ST_SLEEP) ? sleep_ff[MODE_BIT] : on_ff[MODE_BIT];
      if (hwActive) begin
         nxt_vcode = gen_ff[HWC_VPICK_BIT] ? sleep_ff[VCODE_LSB +: 5]
                                           : on_ff[VCODE_LSB +: 5];
         case (hwState)
            HWS_OFF: nxt_enable = 1'b0;
            HWS_FOLLOW: nxt_lowPower = on_ff[MODE_BIT];
            default: nxt_lowPower = 1'b1;
         endcase
      end
      // Codes 00h-0Ch fine steps, 0Dh-1Fh coarse steps
      if (nxt_vcode < V_KNEE_CODE) begin
         nxt_mv = V_BASE_MV + 12'(nxt_vcode * V_FINE_MV);
      end else begin
         nxt_mv = V_KNEE_MV + 12'((nxt_vcode - V_KNEE_CODE) * V_COARSE_MV);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regEnable_ff <= 1'b0;
         vcode_ff <= 5'h00;
         mv_ff <= V_BASE_MV;
         lowPower_ff <= 1'b0;
         discharge_ff <= 1'b1;
         switch_ff <= 1'b0;
      end else begin
         regEnable_ff <= nxt_enable;
         vcode_ff <= nxt_vcode;
         mv_ff <= nxt_mv;
         lowPower_ff <= nxt_lowPower;
         discharge_ff <= !nxt_enable && !gen_ff[FLOAT_BIT];
         switch_ff <= gen_ff[SWITCH_BIT];
      end
   end

   assign regEnable = regEnable_ff;
   assign voltageCode = vcode_ff;
   assign outputMillivolt = mv_ff;
   assign lowPower = lowPower_ff;
   assign outputDischarge = discharge_ff;
   assign switchMode = switch_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   uv_irq_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      uvRise |=> irqStat_ff[IRQ_UV_BIT])
      else $error("undervoltage did not set status");
   uv_reg_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      uvRise && uvAct == UV_REG_OFF |=> state_ff == ST_OFF ##1 !regEnable)
      else $error("regulator not shut down on undervoltage");
   uv_sys_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      uvRise && uvAct == UV_SYS_OFF |=> systemShutdown ##1 !systemShutdown)
      else $error("system shutdown pulse wrong");
   hwc_none_a: assert property (@(posedge clk) disable iff (!rst_b)
      hwSrc == HWC_NONE && state_ff == ST_SLEEP |=> voltageCode == $past(sleep_ff[4:0]))
      else $error("hardware control leaked with source off");
   hwc_vpick_a: assert property (@(posedge clk) disable iff (!rst_b)
      hwActive && gen_ff[HWC_VPICK_BIT] |=> voltageCode == $past(sleep_ff[4:0]))
      else $error("hardware voltage pick wrong");
   hwc_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      hwActive && hwState == HWS_OFF |=> !regEnable)
      else $error("hardware control did not turn off");
   hwc_low_power_a: assert property (@(posedge clk) disable iff (!rst_b)
      hwActive && !hwState[0] |=> lowPower)
      else $error("hardware control low power missing");
   float_ctrl_a: assert property (@(posedge clk) disable iff (!rst_b)
      !regEnable |-> outputDischarge == !$past(gen_ff[FLOAT_BIT]))
      else $error("discharge does not follow float bit");
   slot_enable_a: assert property (@(posedge clk) disable iff (!rst_b)
      seqStep && !seqSleeping && !uvRise && !hwEnAssigned && onSlot != SLOT_NEVER
      && seqSlot == onSlot |=> state_ff == ST_ON)
      else $error("timeslot did not enable");
   sleep_disable_a: assert property (@(posedge clk) disable iff (!rst_b)
      seqStep && seqSleeping && !uvRise && !hwEnAssigned && state_ff == ST_ON
      && slpSlot == SLP_DIS_FIRST && seqSlot == TS5 |=> state_ff == ST_OFF)
      else $error("sleep slot did not disable");
   knee_code_a: assert property (@(posedge clk) disable iff (!rst_b)
      voltageCode == V_KNEE_CODE |-> outputMillivolt == V_KNEE_MV)
      else $error("voltage map wrong at knee");
   uv_irq_c: cover property (@(posedge clk) disable iff (!rst_b) uvRise ##1 irq);
   sleep_entry_c: cover property (@(posedge clk) disable iff (!rst_b)
      state_ff == ST_ON ##1 state_ff == ST_SLEEP);
   hwc_active_c: cover property (@(posedge clk) disable iff (!rst_b) hwActive && regEnable);
   sys_off_c: cover property (@(posedge clk) disable iff (!rst_b) systemShutdown);
endmodule // rcr_regulator_control

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the regulator control registers
// Assumes: Outputs settle within three cycles of their cause
// Notes: Expected values are computed here from the field codes
`timescale 1ns/1ps
module tb_top
   import rcr_pkg::*;
;
////////////////////////////////////////////////////////////////////////////////
logic clk = 1'b0;
logic rst_b = 1'b0;
logic [RCR_ADDR_W-1:0] awaddr = '0;
logic [RCR_ADDR_W-1:0] araddr = '0;
logic [31:0] wdata = '0;
logic [3:0] wstrb = 4'hF;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
logic hwControl1 = 1'b0, hwControl2 = 1'b0, hwEnable1 = 1'b0, hwEnable2 = 1'b0;
logic seqStep = 1'b0, seqSleeping = 1'b0, underVoltage = 1'b0;
logic [2:0] seqSlot = 3'h0;
logic awready, wready, bvalid, arready, rvalid, regEnable, lowPower, outputDischarge;
logic switchMode, priorSleepCode, systemShutdown, irq;
logic [1:0] bresp, rresp, wres;
logic [31:0] rdata;
logic [4:0] voltageCode;
logic [11:0] outputMillivolt;
// Expected read-back words of the register model, oldest first
logic [31:0] expQ [$];
int errCount = 0, totalChecks = 0, shutCnt = 0;
int seed = 32'h99596D6F;
logic [15:0] ix [4] = '{IDX_B_SLEEP, IDX_C_GEN, IDX_C_ON, IDX_C_SLEEP};
logic [15:0] mk [4] = '{16'h001F, 16'hDFC0, 16'hE11F, 16'hE11F};
logic [4:0] vc [5] = '{5'h00, 5'h0C, 5'h0D, 5'h1E, 5'h1F};
logic [2:0] tc [3] = '{3'h0, 3'h6, 3'h7};
logic [2:0] ts [3] = '{3'h5, 3'h3, 3'h1};

rcr_regulator_control dut_u (.clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
   .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
   .rready, .hwControl1, .hwControl2, .hwEnable1, .hwEnable2, .seqStep, .seqSleeping, .seqSlot,
   .underVoltage, .regEnable, .voltageCode, .outputMillivolt, .lowPower, .outputDischarge,
   .switchMode, .priorSleepCode, .systemShutdown, .irq);

always #2.5 clk = ~clk;
// Counted so a stuck or doubled shutdown pulse shows up
always @(posedge clk) if (systemShutdown === 1'b1) shutCnt <= shutCnt + 1;
////////////////////////////////////////////////////////////////////////////////
function automatic int mv(input int c);
   return (c < 13) ? 1000 + 50 * c : 1700 + 100 * (c - 13);
endfunction

task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
   totalChecks++;
   if (got !== exp) begin
      errCount++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
   end
endtask

// Ends mid-cycle so outputs are read settled, away from the launching edge
task automatic settle;
   repeat (3) @(posedge clk);
   @(negedge clk);
endtask

// Address and data offered together; each dropped only at its own acceptance
task automatic wr(input logic [15:0] idx, input logic [15:0] v);
   logic awGo, wGo, bGo;
   @(posedge clk);
   awaddr <= {idx, 2'b00};
   wdata <= {16'h0000, v};
   awvalid <= 1'b1;
   wvalid <= 1'b1;
   bready <= 1'b1;
   do begin
      // Handshake seen mid-cycle, acted on at the edge that completes it
      @(negedge clk);
      awGo = awvalid && awready;
      wGo = wvalid && wready;
      bGo = bvalid;
      wres = bresp;
      @(posedge clk);
      if (awGo) awvalid <= 1'b0;
      if (wGo) wvalid <= 1'b0;
   end while (bGo !== 1'b1);
   bready <= 1'b0;
endtask

task automatic rc(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
   logic arGo, rGo;
   logic [31:0] rd;
   logic [1:0] rr;
   @(posedge clk);
   araddr <= {idx, 2'b00};
   arvalid <= 1'b1;
   rready <= 1'b1;
   do begin
      @(negedge clk);
      arGo = arvalid && arready;
      rGo = rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge clk);
      if (arGo) arvalid <= 1'b0;
   end while (rGo !== 1'b1);
   rready <= 1'b0;
   cmp(rd, exp, "read data");
   cmp(rr, er, "read resp");
endtask

task automatic pins(input logic [4:0] c, input logic lp);
   cmp(regEnable, 1, "enable");
   cmp(voltageCode, c, "code");
   cmp(outputMillivolt, mv(c), "millivolt");
   cmp(lowPower, lp, "low power");
endtask

task automatic step(input logic s, input logic [2:0] t);
   @(posedge clk);
   seqStep <= 1'b1;
   seqSleeping <= s;
   seqSlot <= t;
   @(posedge clk);
   seqStep <= 1'b0;
   settle;
endtask

task automatic uvp;
   @(posedge clk) underVoltage <= 1'b1;
   settle;
   @(posedge clk) underVoltage <= 1'b0;
   settle;
endtask

task automatic printVerdict;
   $display("Checks %0d, mismatches %0d", totalChecks, errCount);
   if (errCount == 0 && totalChecks > 0) $display("Result: passed");
   else $display("Result: failed");
   $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
   int c;
   logic [15:0] v;
   repeat (6) @(posedge clk);
   rst_b <= 1'b1;
   rc(IDX_B_SLEEP, 32'h0000, RESP_OKAY);
   rc(IDX_C_GEN, 32'h0200, RESP_OKAY);
   rc(IDX_C_ON, 32'h0000, RESP_OKAY);
   rc(IDX_C_SLEEP, 32'h0100, RESP_OKAY);
   rc(16'h4095, 32'h0000, RESP_SLVERR);
   wr(16'h4095, 16'hFFFF);
   cmp(wres, RESP_SLVERR, "unmapped write");
   for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      expQ.push_back({16'h0000, v & mk[i]});
      wr(ix[i], v);
      cmp(wres, RESP_OKAY, "mapped write");
      rc(ix[i], expQ.pop_front(), RESP_OKAY);
      if (i == 0) cmp(priorSleepCode, |v[4:0], "prior code");
   end
   wr(IDX_C_GEN, 16'h0000);
   $display("Test registers done");
   for (int s = 1; s <= 5; s++) begin
      wr(IDX_C_ON, {3'(s), 4'h0, 1'(s % 2), 3'h0, vc[s-1]});
      wr(IDX_C_SLEEP, {3'(6 - s), 13'h0000});
      step(1'b0, 3'(s % 5 + 1));
      cmp(regEnable, 0, "early");
      step(1'b0, 3'(s));
      pins(vc[s-1], 1'(s % 2));
      step(1'b1, 3'(s));
      cmp(regEnable, 0, "disable");
      cmp(outputDischarge, 1, "discharge");
   end
   wr(IDX_C_GEN, 16'h00C0);
   settle;
   cmp(outputDischarge, 0, "float");
   cmp(switchMode, 1, "switch");
   wr(IDX_C_ON, 16'h0011);
   for (int t = 1; t <= 5; t++) step(1'b0, 3'(t));
   cmp(regEnable, 0, "never");
   wr(IDX_C_GEN, 16'h0000);
   $display("Test power-up done");
   wr(IDX_C_ON, 16'hC005);
   wr(IDX_C_SLEEP, 16'h4009);
   @(posedge clk) hwEnable1 <= 1'b1;
   settle;
   pins(5'h05, 1'b0);
   step(1'b1, 3'h4);
   pins(5'h09, 1'b0);
   @(posedge clk) hwEnable1 <= 1'b0;
   settle;
   cmp(regEnable, 0, "enable 1 low");
   wr(IDX_C_ON, 16'hE005);
   @(posedge clk) hwEnable2 <= 1'b1;
   settle;
   pins(5'h05, 1'b0);
   @(posedge clk) hwEnable2 <= 1'b0;
   $display("Test hardware enable done");
   for (int k = 0; k < 3; k++) begin
      wr(IDX_C_ON, {8'h20, 3'h0, 5'(k + 3)});
      wr(IDX_C_SLEEP, {tc[k], 4'h0, 1'b1, 8'h1F});
      step(1'b0, 3'h1);
      step(1'b1, 3'h2);
      pins(5'(k + 3), 1'b0);
      step(1'b1, ts[k]);
      pins(5'h1F, 1'b1);
   end
   $display("Test sleep done");
   wr(IDX_C_ON, 16'h2004);
   wr(IDX_C_SLEEP, 16'h0000);
   wr(IDX_IRQ_MASK, 16'h0003);
   for (int a = 0; a < 4; a++) begin
      wr(IDX_C_GEN, {2'(a), 14'h0000});
      step(1'b0, 3'h1);
      c = shutCnt;
      uvp;
      cmp(irq, 1, "irq");
      if (a != 2) cmp(regEnable, a != 1, "uv enable");
      cmp(shutCnt - c, a == 2, "shutdown");
      rc(IDX_IRQ_STAT, (a == 1) ? 32'h3 : 32'h1, RESP_OKAY);
      cmp(irq, 0, "irq cleared");
   end
   wr(IDX_IRQ_MASK, 16'h0000);
   uvp;
   cmp(irq, 0, "masked");
   rc(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
   $display("Test undervoltage done");
   for (int i = 0; i < 16; i++) begin
      wr(IDX_C_GEN, {3'h0, 2'(i / 4), 3'h1, 8'h00});
      @(posedge clk) {hwControl2, hwControl1} <= 2'(i);
      settle;
      cmp(regEnable, !(i[2] & i[0] | i[3] & i[1]), "hw off");
   end
   wr(IDX_C_SLEEP, 16'h0012);
   wr(IDX_C_GEN, 16'h0F00);
   settle;
   pins(5'h12, 1'b0);
   wr(IDX_C_GEN, 16'h0800);
   settle;
   pins(5'h04, 1'b1);
   $display("Test hardware control done");
   printVerdict;
end

initial begin
   #100000;
   errCount++;
   $display("Error at %0t: watchdog expired", $time);
   printVerdict;
end
endmodule // tb_top
